/* File: src/gate_ctrl_pkg.sv */
package gate_ctrl_pkg;

    // =========================================================================
    // Register port, phase and fault geometry
    // =========================================================================
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int PHASES = 3;
    localparam int FAULTS = 4;

    // =========================================================================
    // Register addresses
    // =========================================================================
    localparam logic [ADDR_W-1:0] ADDR_DEADTIME = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_TICK_CAL = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_SIMUL_KEY = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_SIMUL_CTRL = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_FAULT_MASK = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_FAULT_STAT = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_GATE_STAT = 4'h7;

    // =========================================================================
    // Field positions
    // =========================================================================
    localparam int MODE_FULL_DUTY = 0;
    localparam int MODE_DESAT_STOP = 1;
    localparam int MODE_ZERO_DT = 2;
    localparam int MODE_LOCK = 3;
    localparam int SIMUL_EN_BIT = 0;
    localparam int SIMUL_DONE_BIT = 1;
    localparam int FAULT_OVERCUR = 0;
    localparam int FAULT_DESAT = 1;
    localparam int FAULT_PHASE = 2;
    localparam int FAULT_UNDERV = 3;

    // =========================================================================
    // Reset values and unlock keys
    // =========================================================================
    localparam logic [DATA_W-1:0] DEADTIME_RST = 8'h00;
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [FAULTS-1:0] FAULT_MASK_RST = 4'hF;
    localparam logic [DATA_W-1:0] SIMUL_KEY_FIRST = 8'hA5;
    localparam logic [DATA_W-1:0] SIMUL_KEY_SECOND = 8'h5A;

    // =========================================================================
    // Timing
    // =========================================================================
    localparam int CLK_PERIOD_NS = 8;
    localparam int DT_STEP_NS = 50;
    localparam int DT_MAX_NS = 12000;
    localparam int RESET_MAX_NS = 77;
    localparam logic [DATA_W-1:0] DT_MAX_STEPS = DATA_W'(DT_MAX_NS / DT_STEP_NS);
    localparam logic [3:0] TICK_CYCLES_RST =
        4'((DT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int RESET_MAX_CYCLES = RESET_MAX_NS / CLK_PERIOD_NS;

    // =========================================================================
    // Unlock sequence
    // =========================================================================
    typedef enum logic [3:0] {
        SIM_IDLE = 4'b0001,
        SIM_KEYED = 4'b0010,
        SIM_ARMED = 4'b0100,
        SIM_DONE = 4'b1000
    } simul_state_e;

endpackage : gate_ctrl_pkg

/* File: src/phase_deadtime_channel.sv */
`timescale 1ns/100ps
module phase_deadtime_channel
    import gate_ctrl_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic upper_cmd_n_in,
    input wire logic lower_cmd_in,
    input wire logic enable_in,
    input wire logic tick_in,
    input wire logic [DATA_W-1:0] dead_steps_in,
    input wire logic simul_in,
    input wire logic zero_dt_in,
    output logic upper_gate_out,
    output logic lower_gate_out,
    output logic boot_ready_out
);

    logic prev_up_n_q;
    logic prev_lo_q;
    logic pend_up_q, pend_up_d;
    logic pend_lo_q, pend_lo_d;
    logic up_d, lo_d, boot_d;
    logic [DATA_W-1:0] timer_q;
    logic load;
    logic busy;
    logic up_lead, up_trail, lo_lead, lo_trail;

    // =========================================================================
    // Edge detection
    // =========================================================================
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            prev_up_n_q <= 1'b1;
            prev_lo_q <= 1'b0;
        end else begin
            prev_up_n_q <= upper_cmd_n_in;
            prev_lo_q <= lower_cmd_in;
        end
    end

    assign up_lead = prev_up_n_q & ~upper_cmd_n_in;
    assign up_trail = ~prev_up_n_q & upper_cmd_n_in;
    assign lo_lead = ~prev_lo_q & lower_cmd_in;
    assign lo_trail = prev_lo_q & ~lower_cmd_in;

    // =========================================================================
    // Gate decision
    // =========================================================================
    // Outside simultaneous-on mode, a lower edge wins over an upper edge in one cycle, since that order
    // also recharges the bootstrap capacitor.
    always_comb begin
        up_d = upper_gate_out;
        lo_d = lower_gate_out;
        pend_up_d = pend_up_q;
        pend_lo_d = pend_lo_q;
        boot_d = boot_ready_out;
        load = 1'b0;
        busy = 1'b0;
        if (!enable_in) begin
            load = upper_gate_out | lower_gate_out;
            up_d = 1'b0;
            lo_d = 1'b0;
            pend_up_d = 1'b0;
            pend_lo_d = 1'b0;
            boot_d = 1'b0;
        end else if (simul_in) begin
            pend_up_d = 1'b0;
            pend_lo_d = 1'b0;
            if (lo_lead) begin
                lo_d = 1'b1;
            end else if (lo_trail) begin
                lo_d = 1'b0;
            end
            if (up_lead && boot_ready_out) begin
                up_d = 1'b1;
            end else if (up_trail) begin
                up_d = 1'b0;
            end
        end else begin
            if (up_trail) begin
                pend_up_d = 1'b0;
                if (upper_gate_out) begin
                    up_d = 1'b0;
                    load = 1'b1;
                end
            end
            if (lo_trail) begin
                pend_lo_d = 1'b0;
                if (lower_gate_out) begin
                    lo_d = 1'b0;
                    load = 1'b1;
                end
            end
            if (lo_lead) begin
                pend_lo_d = 1'b1;
                pend_up_d = 1'b0;
                if (upper_gate_out) begin
                    up_d = 1'b0;
                    load = 1'b1;
                end
            end else if (up_lead) begin
                pend_up_d = 1'b1;
                pend_lo_d = 1'b0;
                if (lower_gate_out) begin
                    lo_d = 1'b0;
                    load = 1'b1;
                end
            end
            busy = load || (timer_q != '0 && !zero_dt_in);
            if (!busy) begin
                if (pend_lo_d) begin
                    lo_d = 1'b1;
                    pend_lo_d = 1'b0;
                end else if (pend_up_d) begin
                    up_d = boot_ready_out;
                    pend_up_d = 1'b0;
                end
            end
        end
        if (lo_d) begin
            boot_d = 1'b1;
        end
        if (!simul_in && lo_d) begin
            up_d = 1'b0;
        end
    end

    // =========================================================================
    // Gate and pending state
    // =========================================================================
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            upper_gate_out <= 1'b0;
            lower_gate_out <= 1'b0;
            pend_up_q <= 1'b0;
            pend_lo_q <= 1'b0;
            boot_ready_out <= 1'b0;
        end else begin
            upper_gate_out <= up_d;
            lower_gate_out <= lo_d;
            pend_up_q <= pend_up_d;
            pend_lo_q <= pend_lo_d;
            boot_ready_out <= boot_d;
        end
    end

    // =========================================================================
    // Deadtime timer, counts shared step ticks
    // =========================================================================
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            timer_q <= '0;
        end else if (load) begin
            timer_q <= zero_dt_in ? '0 : dead_steps_in;
        end else if (tick_in && timer_q != '0) begin
            timer_q <= timer_q - 1'b1;
        end
    end

endmodule : phase_deadtime_channel

/* File: src/gate_ctrl_top.sv */
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
module gate_ctrl_top
    import gate_ctrl_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [DATA_W-1:0] reg_rdata_out,
    input wire logic [PHASES-1:0] upper_switch_cmd_n_in,
    input wire logic [PHASES-1:0] lower_switch_cmd_in,
    input wire logic gate_enable_first_in,
    input wire logic gate_enable_second_in,
    input wire logic [FAULTS-1:0] fault_in,
    output logic [PHASES-1:0] upper_gate_out,
    output logic [PHASES-1:0] lower_gate_out,
    output logic fault_report_out,
    output logic full_duty_mode_out
);

    // =========================================================================
    // Configuration state
    // =========================================================================
    logic [DATA_W-1:0] deadtime_q;
    logic [3:0] tick_cal_q;
    logic [3:0] tick_cnt_q;
    logic tick_q;
    logic [2:0] mode_q;
    logic mode_lock_q;
    simul_state_e simul_state_q;
    logic simul_en_q;
    logic [FAULTS-1:0] fault_mask_q;
    logic [FAULTS-1:0] fault_stat_q;
    logic gates_enabled;
    logic desat_kill;
    logic phase_enable;
    logic [PHASES-1:0] boot_ready;
    logic wr_deadtime, wr_tick_cal, wr_mode, wr_key, wr_simul, wr_mask, wr_stat;
    logic [DATA_W-1:0] rdata_d;

    assign wr_deadtime = reg_write_in && reg_addr_in == ADDR_DEADTIME;
    assign wr_tick_cal = reg_write_in && reg_addr_in == ADDR_TICK_CAL;
    assign wr_mode = reg_write_in && reg_addr_in == ADDR_MODE;
    assign wr_key = reg_write_in && reg_addr_in == ADDR_SIMUL_KEY;
    assign wr_simul = reg_write_in && reg_addr_in == ADDR_SIMUL_CTRL;
    assign wr_mask = reg_write_in && reg_addr_in == ADDR_FAULT_MASK;
    assign wr_stat = reg_write_in && reg_addr_in == ADDR_FAULT_STAT;

    // =========================================================================
    // Deadtime setting
    // =========================================================================
    // Values beyond the longest deadtime are clamped so the timer never
    // exceeds its range.
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            deadtime_q <= DEADTIME_RST;
        end else if (wr_deadtime) begin
            if (reg_wdata_in > DT_MAX_STEPS) begin
                deadtime_q <= DT_MAX_STEPS;
            end else begin
                deadtime_q <= reg_wdata_in;
            end
        end
    end

    // =========================================================================
    // Step calibration and shared tick
    // =========================================================================
    // The step is a whole number of clocks, so calibration can only
    // correct process spread in whole clock periods.
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            tick_cal_q <= TICK_CYCLES_RST;
        end else if (wr_tick_cal) begin
            if (reg_wdata_in[3:0] == 4'h0) begin
                tick_cal_q <= 4'h1;
            end else begin
                tick_cal_q <= reg_wdata_in[3:0];
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            tick_cnt_q <= 4'h0;
            tick_q <= 1'b0;
        end else if (tick_cnt_q + 4'h1 >= tick_cal_q) begin
            tick_cnt_q <= 4'h0;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 4'h1;
            tick_q <= 1'b0;
        end
    end

    // =========================================================================
    // Operating modes with lock
    // =========================================================================
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            mode_q <= MODE_RST;
            mode_lock_q <= 1'b0;
        end else if (wr_mode && !mode_lock_q) begin
            mode_q <= reg_wdata_in[2:0];
            mode_lock_q <= reg_wdata_in[MODE_LOCK];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            full_duty_mode_out <= 1'b0;
        end else begin
            full_duty_mode_out <= mode_q[MODE_FULL_DUTY];
        end
    end

    // =========================================================================
    // Simultaneous-on unlock and once-only command
    // =========================================================================
    // A wrong key returns to idle, so a stray write cannot arm it.
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            simul_state_q <= SIM_IDLE;
            simul_en_q <= 1'b0;
        end else begin
            unique case (simul_state_q)
                SIM_IDLE: begin
                    if (wr_key && reg_wdata_in == SIMUL_KEY_FIRST) begin
                        simul_state_q <= SIM_KEYED;
                    end
                end
                SIM_KEYED: begin
                    if (wr_key) begin
                        if (reg_wdata_in == SIMUL_KEY_SECOND) begin
                            simul_state_q <= SIM_ARMED;
                        end else begin
                            simul_state_q <= SIM_IDLE;
                        end
                    end
                end
                SIM_ARMED: begin
                    if (wr_simul) begin
                        simul_en_q <= reg_wdata_in[SIMUL_EN_BIT];
                        simul_state_q <= SIM_DONE;
                    end else if (wr_key) begin
                        simul_state_q <= SIM_IDLE;
                    end
                end
                SIM_DONE: begin
                    simul_state_q <= SIM_DONE;
                end
                default: begin
                    simul_state_q <= SIM_DONE;
                    simul_en_q <= 1'b0;
                end
            endcase
        end
    end

    // =========================================================================
    // Fault mask and sticky fault status
    // =========================================================================
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            fault_mask_q <= FAULT_MASK_RST;
        end else if (wr_mask) begin
            fault_mask_q <= reg_wdata_in[FAULTS-1:0];
        end
    end

    // Set wins over a clear in the same cycle.
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            fault_stat_q <= '0;
        end else if (wr_stat) begin
            fault_stat_q <= (fault_stat_q & ~reg_wdata_in[FAULTS-1:0]) | fault_in;
        end else begin
            fault_stat_q <= fault_stat_q | fault_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            fault_report_out <= 1'b0;
        end else begin
            fault_report_out <= |(fault_stat_q & fault_mask_q);
        end
    end

    // =========================================================================
    // Register read-back
    // =========================================================================
    always_comb begin
        rdata_d = '0;
        unique case (reg_addr_in)
            ADDR_DEADTIME: rdata_d = deadtime_q;
            ADDR_TICK_CAL: rdata_d = {4'h0, tick_cal_q};
            ADDR_MODE: rdata_d = {4'h0, mode_lock_q, mode_q};
            ADDR_SIMUL_KEY: rdata_d = {4'h0, simul_state_q};
            ADDR_SIMUL_CTRL: begin
                rdata_d = {6'h00, simul_state_q == SIM_DONE, simul_en_q};
            end
            ADDR_FAULT_MASK: rdata_d = {4'h0, fault_mask_q};
            ADDR_FAULT_STAT: rdata_d = {4'h0, fault_stat_q};
            ADDR_GATE_STAT: begin
                rdata_d = {1'b0, boot_ready, 1'b0, upper_gate_out[2], lower_gate_out[2],
                    gates_enabled};
            end
            default: rdata_d = '0;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= '0;
        end else if (reg_read_in) begin
            reg_rdata_out <= rdata_d;
        end else begin
            reg_rdata_out <= '0;
        end
    end

    // =========================================================================
    // Phase channels
    // =========================================================================
    // Enables are synchronous levels; in desaturation stop mode a live
    // desaturation fault also forces every gate off.
    assign gates_enabled = gate_enable_first_in & gate_enable_second_in;
    assign desat_kill = mode_q[MODE_DESAT_STOP] & fault_in[FAULT_DESAT];
    assign phase_enable = gates_enabled & ~desat_kill;

    genvar ph;
    generate
        for (ph = 0; ph < PHASES; ph++) begin : g_phase
            phase_deadtime_channel u_channel (
                .ref_clk_in(ref_clk_in),
                .sys_rst_in(sys_rst_in),
                .upper_cmd_n_in(upper_switch_cmd_n_in[ph]),
                .lower_cmd_in(lower_switch_cmd_in[ph]),
                .enable_in(phase_enable),
                .tick_in(tick_q),
                .dead_steps_in(deadtime_q),
                .simul_in(simul_en_q),
                .zero_dt_in(mode_q[MODE_ZERO_DT]),
                .upper_gate_out(upper_gate_out[ph]),
                .lower_gate_out(lower_gate_out[ph]),
                .boot_ready_out(boot_ready[ph])
            );
        end
    endgenerate

endmodule : gate_ctrl_top

/* File: verif/gate_ctrl_asserts.sv */
`timescale 1ns/100ps
// ====================
// Port checks
module gate_ctrl_asserts
    import gate_ctrl_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [DATA_W-1:0] reg_rdata_out,
    input wire logic [PHASES-1:0] lower_switch_cmd_in,
    input wire logic gate_enable_first_in,
    input wire logic gate_enable_second_in,
    input wire logic [PHASES-1:0] upper_gate_out,
    input wire logic [PHASES-1:0] lower_gate_out,
    input wire logic full_duty_mode_out
);
    logic simul_q;
    logic booted_q;
    wire logic en_w = gate_enable_first_in && gate_enable_second_in;

    // Any enable attempt relaxes the overlap checks.
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            simul_q <= 1'b0;
        end else if (reg_write_in && reg_addr_in == ADDR_SIMUL_CTRL && reg_wdata_in[0]) begin
            simul_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || !en_w) begin
            booted_q <= 1'b0;
        end else if (lower_gate_out[0]) begin
            booted_q <= 1'b1;
        end
    end

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_lead_lower;
        $rose(lower_switch_cmd_in[0]) && !simul_q;
    endsequence
    sequence s_mode_wr;
        reg_write_in && reg_addr_in == ADDR_MODE;
    endsequence

    a_no_overlap: assert property (!simul_q |-> !(|(upper_gate_out & lower_gate_out)))
        else $error("phase overlap");
    a_comp_off: assert property (s_lead_lower |-> ##2 !upper_gate_out[0])
        else $error("upper gate kept");
    a_trail_off: assert property ($fell(lower_switch_cmd_in[0]) |-> ##2 !lower_gate_out[0])
        else $error("lower gate kept");
    a_dead_gap: assert property ($rose(upper_gate_out[0]) && !simul_q |-> !$past(lower_gate_out[0]))
        else $error("no deadtime gap");
    a_boot_first: assert property ($rose(upper_gate_out[0]) |-> booted_q)
        else $error("upper gate before lower");
    a_enable_off: assert property ((!en_w)[*2] |-> upper_gate_out == 3'h0 && lower_gate_out == 3'h0)
        else $error("gates on, disabled");
    a_reset_out: assert property ($fell(sys_rst_in) |-> {upper_gate_out, lower_gate_out, reg_rdata_out, full_duty_mode_out} == '0)
        else $error("reset outputs not zero");
    a_unmapped_rd: assert property (reg_read_in && reg_addr_in > ADDR_GATE_STAT |=> reg_rdata_out == 8'h00)
        else $error("unmapped read");
    a_mode_cause: assert property ($changed(full_duty_mode_out) |-> $past(reg_write_in, 2) && $past(reg_addr_in, 2) == ADDR_MODE)
        else $error("full duty moved alone");
    c_mode_wr: cover property (s_mode_wr ##2 $changed(full_duty_mode_out));
endmodule : gate_ctrl_asserts

bind gate_ctrl_top gate_ctrl_asserts u_gate_ctrl_asserts (.ref_clk_in, .sys_rst_in, .reg_addr_in,
    .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .lower_switch_cmd_in,
    .gate_enable_first_in, .gate_enable_second_in, .upper_gate_out, .lower_gate_out,
    .full_duty_mode_out);

/* File: verif/mcu_phase_model.sv */
`timescale 1ns/100ps
// ====================
// Host command source
module mcu_phase_model
    import gate_ctrl_pkg::*;
(
    input wire logic ref_clk_in,
    output logic [PHASES-1:0] upper_cmd_n_out,
    output logic [PHASES-1:0] lower_cmd_out,
    output logic en_first_out,
    output logic en_second_out
);
    // Idle levels give no false edge at start.
    initial begin
        upper_cmd_n_out = 3'h7;
        lower_cmd_out = 3'h0;
        en_first_out = 1'b0;
        en_second_out = 1'b0;
    end

    task automatic phase_cmd(input int ph, input logic up_on, input logic lo_on);
        @(posedge ref_clk_in);
        upper_cmd_n_out[ph] <= !up_on;
        lower_cmd_out[ph] <= lo_on;
    endtask : phase_cmd

    task automatic enables(input logic a, input logic b);
        @(posedge ref_clk_in);
        en_first_out <= a;
        en_second_out <= b;
    endtask : enables
endmodule : mcu_phase_model

/* File: verif/three_phase_deadtime_gate_control_test.sv */
`timescale 1ns/100ps
// ====================
// Stimulus and scoreboard
module three_phase_deadtime_gate_control_test
    import gate_ctrl_pkg::*;
;
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic reg_write_in = 1'b0;
    logic reg_read_in = 1'b0;
    logic rd_d = 1'b0;
    logic look = 1'b0;
    logic [ADDR_W-1:0] reg_addr_in = '0;
    logic [DATA_W-1:0] reg_wdata_in = '0;
    logic [DATA_W-1:0] reg_rdata_out;
    logic [FAULTS-1:0] fault_in = '0;
    logic [PHASES-1:0] up_n, lo, upper_gate_out, lower_gate_out;
    logic en1, en2, fault_report_out, full_duty_mode_out;
    logic [7:0] exp_q[$];
    logic [7:0] f, d, cal;
    int n_mismatch = 0;
    int check_count = 0;
    int c;
    wire logic [7:0] obs_w = {fault_report_out, full_duty_mode_out, upper_gate_out, lower_gate_out};

    always #4 ref_clk_in = ~ref_clk_in;

    gate_ctrl_top u_gate_ctrl_top (.ref_clk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in,
        .reg_write_in, .reg_read_in, .reg_rdata_out, .upper_switch_cmd_n_in(up_n),
        .lower_switch_cmd_in(lo), .gate_enable_first_in(en1), .gate_enable_second_in(en2),
        .fault_in, .upper_gate_out, .lower_gate_out, .fault_report_out, .full_duty_mode_out);
    mcu_phase_model u_mcu_phase_model (.ref_clk_in, .upper_cmd_n_out(up_n),
        .lower_cmd_out(lo), .en_first_out(en1), .en_second_out(en2));

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge ref_clk_in);
        reg_write_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= v;
        @(posedge ref_clk_in);
        reg_write_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk_in);
        exp_q.push_back(e);
        reg_read_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge ref_clk_in);
        reg_read_in <= 1'b0;
    endtask : rd
    task automatic obs(input logic [7:0] e);
        @(posedge ref_clk_in);
        exp_q.push_back(e);
        look <= 1'b1;
        @(posedge ref_clk_in);
        look <= 1'b0;
    endtask : obs
    task automatic pc(input logic u, input logic l);
        u_mcu_phase_model.phase_cmd(0, u, l);
    endtask : pc
    // Counts edges until the phase A gate is on.
    task automatic wait_g(input logic up, output int n);
        n = 0;
        #1;
        while (((up ? upper_gate_out[0] : lower_gate_out[0]) !== 1'b1) && n < 600) begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
    endtask : wait_g
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    always @(posedge ref_clk_in) begin
        if (rd_d) begin
            chk("read data", reg_rdata_out, exp_q.pop_front());
        end else if (look) begin
            chk("outputs", obs_w, exp_q.pop_front());
        end
        rd_d <= reg_read_in;
    end

    initial begin
        #400000;
        n_mismatch++;
        close_out();
    end

    initial begin
        void'($urandom(32'hF52BD745));
        tick(8);
        sys_rst_in <= 1'b0;
        rd(ADDR_DEADTIME, DEADTIME_RST);
        rd(ADDR_TICK_CAL, {4'h0, TICK_CYCLES_RST});
        rd(ADDR_FAULT_MASK, {4'h0, FAULT_MASK_RST});
        rd(4'hC, 8'h00);
        wr(ADDR_MODE, 8'h01);
        tick(2);
        obs(8'h40);
        wr(ADDR_MODE, 8'h08);
        wr(ADDR_MODE, 8'h01);
        rd(ADDR_MODE, 8'h08);
        obs(8'h00);
        $display("register test done");
        wr(ADDR_FAULT_MASK, 8'h00);
        f = {4'h0, 4'($urandom) | 4'h1};
        fault_in <= f[3:0];
        tick(2);
        fault_in <= 4'h0;
        tick(3);
        obs(8'h00);
        rd(ADDR_FAULT_STAT, f);
        wr(ADDR_FAULT_MASK, 8'h0F);
        tick(2);
        obs(8'h80);
        wr(ADDR_FAULT_STAT, 8'h0F);
        rd(ADDR_FAULT_STAT, 8'h00);
        obs(8'h00);
        $display("fault test done");
        u_mcu_phase_model.enables(1'b1, 1'b1);
        pc(1'b1, 1'b0);
        tick(3);
        obs(8'h00);
        pc(1'b0, 1'b0);
        for (int i = 0; i < 2; i++) begin
            d = 8'(4 + $urandom % 8);
            cal = (i == 0) ? 8'h01 : 8'h03;
            wr(ADDR_DEADTIME, d);
            wr(ADDR_TICK_CAL, cal);
            tick(40);
            pc(1'b0, 1'b1);
            tick(3);
            obs(8'h01);
            pc(1'b1, 1'b1);
            wait_g(1'b1, c);
            chk("upper delay", 8'(c >= (d - 1) * cal + 2 && c <= d * cal + 4), 8'h01);
            obs(8'h08);
            pc(1'b0, 1'b0);
            pc(1'b0, 1'b1);
            wait_g(1'b0, c);
            chk("lower delay", 8'(c >= (d - 1) * cal + 1 && c <= d * cal + 4), 8'h01);
            pc(1'b0, 1'b0);
            tick(40);
            pc(1'b1, 1'b0);
            wait_g(1'b1, c);
            chk("late turn-on", 8'(c <= 2), 8'h01);
            pc(1'b0, 1'b0);
        end
        $display("deadtime test done");
        tick(40);
        pc(1'b1, 1'b0);
        tick(3);
        u_mcu_phase_model.enables(1'b1, 1'b0);
        tick(2);
        obs(8'h00);
        u_mcu_phase_model.enables(1'b1, 1'b1);
        tick(3);
        obs(8'h00);
        pc(1'b0, 1'b0);
        $display("enable test done");
        wr(ADDR_SIMUL_CTRL, 8'h01);
        rd(ADDR_SIMUL_CTRL, 8'h00);
        wr(ADDR_SIMUL_KEY, SIMUL_KEY_FIRST);
        wr(ADDR_SIMUL_KEY, SIMUL_KEY_SECOND);
        rd(ADDR_SIMUL_KEY, 8'h04);
        wr(ADDR_SIMUL_CTRL, 8'h01);
        wr(ADDR_SIMUL_CTRL, 8'h00);
        rd(ADDR_SIMUL_CTRL, 8'h03);
        pc(1'b0, 1'b1);
        tick(3);
        pc(1'b1, 1'b1);
        tick(3);
        obs(8'h09);
        pc(1'b0, 1'b0);
        tick(2);
        sys_rst_in <= 1'b1;
        tick(8);
        sys_rst_in <= 1'b0;
        rd(ADDR_SIMUL_CTRL, 8'h00);
        rd(ADDR_MODE, 8'h00);
        obs(8'h00);
        $display("overlap test done");
        tick(2);
        close_out();
    end
endmodule : three_phase_deadtime_gate_control_test
